// ==== spi_params.svh ====
`ifndef SPI_PARAMS_SVH
`define SPI_PARAMS_SVH

// Reference clock and serial rate limits, in MHz and Mbps
`define SPI_REF_MHZ 16'h00c8
`define SPI_MST_MAX_MBPS 16'h0041
`define SPI_SLV_MAX_MBPS 16'h002d
// Fewest reference cycles per serial clock period, rounded up
`define SPI_MIN_SCK_CYC ((`SPI_REF_MHZ + `SPI_MST_MAX_MBPS - 16'h0001) / `SPI_MST_MAX_MBPS)
// Fewest reference cycles per serial clock half period
`define SPI_MIN_HALF ((`SPI_MIN_SCK_CYC + 16'h0001) / 16'h0002)
// Returning data crosses two synchroniser stages before capture, so three cycles at least
`define SPI_RX_HALF ((`SPI_MIN_HALF > 16'h0003) ? `SPI_MIN_HALF : 16'h0003)

`define SPI_WORD_W 32
`define SPI_FIFO_DEPTH 4
`define SPI_CS_W 2
`define SPI_PACK8_LEN 5'h07
`define SPI_PACK16_LEN 5'h0f
`define SPI_PACK8_PPW 3'h4
`define SPI_PACK16_PPW 3'h2
`define SPI_CFG_RESET 20'h00000

`endif

// ==== spi_pkg.sv ====
`include "spi_params.svh"

package spi_pkg;

    typedef struct packed {
        logic enable;
        logic master;
        logic cpol;
        logic cpha;
        logic [4:0] bit_len;
        logic packed_en;
        logic sw_cs;
        logic sw_cs_level;
        logic cs_sel;
        logic cmp_en;
        logic [7:0] half_div;
    } cfg_t;

    typedef enum logic [2:0] {
        M_IDLE,
        M_SETUP,
        M_SHIFT,
        M_HOLD,
        M_GAP
    } mst_state_t;

endpackage : spi_pkg

// ==== spi_fifo.sv ====
`timescale 1ns/1ps

module spi_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Fill side
    input wire logic wr_valid,
    input wire logic [W-1:0] wr_data,
    output logic wr_ready,
    // Drain side
    output logic rd_valid,
    output logic [W-1:0] rd_data,
    input wire logic rd_ready
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign wr_ready = cnt_q != (AW+1)'(DEPTH);
    assign rd_valid = cnt_q != '0;
    assign rd_data = mem_q[rd_q];
    assign push = wr_valid & wr_ready;
    assign pop = rd_valid & rd_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_q[wr_q] <= wr_data;
        end
    end

    // Depth is a power of two, so the pointers wrap by themselves
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_q + AW'(push);
            rd_q <= rd_q + AW'(pop);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : spi_fifo

// ==== spi_ctrl.sv ====
`timescale 1ns/1ps
`include "spi_params.svh"

module spi_ctrl (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Configuration and status
    input wire spi_pkg::cfg_t cfg,
    input wire logic [31:0] cmp_pattern,
    input wire logic ovr_clr,
    output logic busy,
    output logic cmp_matched,
    output logic rx_overrun,
    // Transmit words
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    output logic tx_ready,
    // Receive words
    output logic rx_valid,
    output logic [31:0] rx_data,
    input wire logic rx_ready,
    // Serial clock pin
    input wire logic sck_line,
    output logic sck_drive,
    output logic sck_oe_n,
    // Data pins
    input wire logic mosi_line,
    output logic mosi_drive,
    output logic mosi_oe_n,
    input wire logic miso_line,
    output logic miso_drive,
    output logic miso_oe_n,
    // Select pins, active low
    input wire logic [`SPI_CS_W-1:0] cs_n_line,
    output logic [`SPI_CS_W-1:0] cs_n_drive,
    output logic [`SPI_CS_W-1:0] cs_oe_n
);

    logic mst_en;
    logic slv_en;
    logic [4:0] len;
    logic [5:0] psize;
    logic [2:0] ppw;
    logic [31:0] len_mask;
    logic [7:0] reload;
    logic [6:0] last_edge;

    assign mst_en = cfg.enable & cfg.master;
    assign slv_en = cfg.enable & ~cfg.master;
    assign len = cfg.bit_len;
    assign psize = {1'b0, len} + 6'h01;
    assign len_mask = 32'hffffffff >> (5'h1f - len);
    assign last_edge = {1'b0, len, 1'b0} + 7'h01;

    always_comb begin
        ppw = 3'h1;
        if (cfg.packed_en && len == `SPI_PACK8_LEN) begin
            ppw = `SPI_PACK8_PPW;
        end else if (cfg.packed_en && len == `SPI_PACK16_LEN) begin
            ppw = `SPI_PACK16_PPW;
        end
    end

    // Floor keeps the rate limit and lets returning data clear its synchroniser
    assign reload = (cfg.half_div < 8'(`SPI_RX_HALF)) ?
                    8'(`SPI_RX_HALF) - 8'h01 : cfg.half_div - 8'h01;

    // Two independent word queues
    logic txf_valid;
    logic [31:0] txf_data;
    logic txf_pop;
    logic rxf_wvalid;
    logic [31:0] rxf_wdata;
    logic rxf_wready;

    spi_fifo #(.W(`SPI_WORD_W), .DEPTH(`SPI_FIFO_DEPTH)) tx_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .wr_valid(tx_valid),
        .wr_data(tx_data),
        .wr_ready(tx_ready),
        .rd_valid(txf_valid),
        .rd_data(txf_data),
        .rd_ready(txf_pop)
    );

    spi_fifo #(.W(`SPI_WORD_W), .DEPTH(`SPI_FIFO_DEPTH)) rx_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .wr_valid(rxf_wvalid),
        .wr_data(rxf_wdata),
        .wr_ready(rxf_wready),
        .rd_valid(rx_valid),
        .rd_data(rx_data),
        .rd_ready(rx_ready)
    );

    // Transmit unpacking: packets leave a word low packet first
    logic [31:0] hold_q;
    logic [2:0] left_q;
    logic tx_avail;
    logic tx_take;
    logic mst_take;
    logic slv_take;

    assign tx_avail = left_q != 3'h0;
    // Words wait in the queue while disabled instead of being lost
    assign txf_pop = cfg.enable & (left_q == 3'h0) & txf_valid;
    assign tx_take = mst_take | slv_take;

    always_ff @(posedge ref_clk) begin
        if (srst || !cfg.enable) begin
            hold_q <= '0;
            left_q <= 3'h0;
        end else if (tx_take) begin
            hold_q <= hold_q >> psize;
            left_q <= left_q - 3'h1;
        end else if (txf_pop) begin
            hold_q <= txf_data;
            left_q <= ppw;
        end
    end

    // Link domain: slave shifting on the external clock
    logic lclk;
    logic lrst;
    logic [4:0] l_cnt_q;
    logic [31:0] l_rsh_q;
    logic [31:0] l_rword_q;
    logic l_rtgl_q;
    logic l_ttgl_q;
    logic l_first_q;
    logic l_miso_q;
    logic [31:0] stx_q;

    // Folding polarity and phase into the clock makes posedge the sample edge
    assign lclk = sck_line ^ cfg.cpol ^ cfg.cpha;
    assign lrst = cs_n_line[0] | ~slv_en;

    always_ff @(posedge lclk or posedge lrst) begin
        if (lrst) begin
            l_cnt_q <= 5'h00;
            l_rsh_q <= '0;
        end else begin
            l_rsh_q <= {l_rsh_q[30:0], mosi_line};
            l_cnt_q <= (l_cnt_q == len) ? 5'h00 : l_cnt_q + 5'h01;
        end
    end

    // Event toggles survive select release so the other side never sees a false event
    always_ff @(posedge lclk or posedge srst) begin
        if (srst) begin
            l_rword_q <= '0;
            l_rtgl_q <= 1'b0;
            l_ttgl_q <= 1'b0;
        end else if (!lrst && l_cnt_q == len) begin
            l_rword_q <= {l_rsh_q[30:0], mosi_line};
            l_rtgl_q <= ~l_rtgl_q;
            l_ttgl_q <= ~l_ttgl_q;
        end
    end

    always_ff @(negedge lclk or posedge lrst) begin
        if (lrst) begin
            l_first_q <= 1'b0;
            l_miso_q <= 1'b0;
        end else begin
            l_first_q <= 1'b1;
            l_miso_q <= stx_q[len - l_cnt_q];
        end
    end

    // The first bit must stand before any edge when phase is zero
    assign miso_drive = l_first_q ? l_miso_q : stx_q[len];
    assign miso_oe_n = ~(slv_en & ~cs_n_line[0]);

    // Crossings into the reference domain
    logic [2:0] rt_sync_q;
    logic [2:0] tt_sync_q;
    logic [1:0] miso_sync_q;
    logic slv_rx_evt;
    logic slv_tx_evt;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rt_sync_q <= 3'h0;
            tt_sync_q <= 3'h0;
            miso_sync_q <= 2'h0;
        end else begin
            rt_sync_q <= {rt_sync_q[1:0], l_rtgl_q};
            tt_sync_q <= {tt_sync_q[1:0], l_ttgl_q};
            miso_sync_q <= {miso_sync_q[0], miso_line};
        end
    end

    assign slv_rx_evt = slv_en & (rt_sync_q[2] ^ rt_sync_q[1]);
    assign slv_tx_evt = slv_en & (tt_sync_q[2] ^ tt_sync_q[1]);

    // Slave transmit word; underrun sends zeros
    logic s_need_q;

    assign slv_take = slv_en & s_need_q & tx_avail & ~slv_tx_evt;

    always_ff @(posedge ref_clk) begin
        if (srst || !slv_en) begin
            s_need_q <= 1'b1;
            stx_q <= '0;
        end else if (slv_tx_evt) begin
            s_need_q <= 1'b1;
            stx_q <= '0;
        end else if (slv_take) begin
            s_need_q <= 1'b0;
            stx_q <= hold_q;
        end
    end

    // Master engine
    spi_pkg::mst_state_t st_q;
    logic [7:0] tmr_q;
    logic [6:0] eidx_q;
    logic sck_q;
    logic [31:0] sh_q;
    logic [31:0] rsh_q;
    logic pv_q;
    logic edge_now;
    logic sample_now;
    logic mst_rx_evt;

    assign edge_now = (st_q == spi_pkg::M_SHIFT) && tmr_q == 8'h00;
    assign sample_now = edge_now && (eidx_q[0] == cfg.cpha);
    assign mst_take = mst_en && st_q == spi_pkg::M_IDLE && tx_avail && !pv_q;
    assign mst_rx_evt = (st_q == spi_pkg::M_HOLD) && tmr_q == 8'h00;

    always_ff @(posedge ref_clk) begin
        if (srst || !mst_en) begin
            st_q <= spi_pkg::M_IDLE;
            tmr_q <= 8'h00;
            eidx_q <= 7'h00;
            sck_q <= cfg.cpol;
            sh_q <= '0;
            rsh_q <= '0;
        end else begin
            case (st_q)
                spi_pkg::M_IDLE: begin
                    sck_q <= cfg.cpol;
                    if (mst_take) begin
                        sh_q <= hold_q;
                        tmr_q <= reload;
                        st_q <= spi_pkg::M_SETUP;
                    end
                end
                spi_pkg::M_SETUP: begin
                    eidx_q <= 7'h00;
                    if (tmr_q == 8'h00) begin
                        tmr_q <= reload;
                        st_q <= spi_pkg::M_SHIFT;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                spi_pkg::M_SHIFT: begin
                    if (edge_now) begin
                        sck_q <= ~sck_q;
                        tmr_q <= reload;
                        eidx_q <= eidx_q + 7'h01;
                        if (sample_now) begin
                            rsh_q <= {rsh_q[30:0], miso_sync_q[1]};
                        end else if (eidx_q != 7'h00) begin
                            sh_q <= sh_q << 1;
                        end
                        if (eidx_q == last_edge) begin
                            st_q <= spi_pkg::M_HOLD;
                        end
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                spi_pkg::M_HOLD: begin
                    if (tmr_q == 8'h00) begin
                        tmr_q <= reload;
                        st_q <= spi_pkg::M_GAP;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                spi_pkg::M_GAP: begin
                    if (tmr_q == 8'h00) begin
                        st_q <= spi_pkg::M_IDLE;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                default: begin
                    st_q <= spi_pkg::M_IDLE;
                end
            endcase
        end
    end

    assign sck_drive = sck_q;
    assign sck_oe_n = ~mst_en;
    assign mosi_drive = sh_q[len];
    assign mosi_oe_n = ~mst_en;

    // Select lines, each driven on its own
    logic [`SPI_CS_W-1:0] cs_q;
    logic pkt_act;

    assign pkt_act = st_q == spi_pkg::M_SETUP || st_q == spi_pkg::M_SHIFT ||
                     st_q == spi_pkg::M_HOLD;

    for (genvar i = 0; i < `SPI_CS_W; i++) begin : g_cs
        always_ff @(posedge ref_clk) begin
            if (srst || !mst_en || cfg.cs_sel != i) begin
                cs_q[i] <= 1'b1;
            end else begin
                cs_q[i] <= cfg.sw_cs ? ~cfg.sw_cs_level : ~pkt_act;
            end
        end
        assign cs_oe_n[i] = ~mst_en;
    end

    assign cs_n_drive = cs_q;

    // Receive compare and packing
    logic rx_evt;
    logic [31:0] rx_pkt;
    logic matched_q;
    logic rx_store;
    logic [31:0] acc_q;
    logic [2:0] acnt_q;
    logic [31:0] pd_q;
    logic [5:0] amt;
    logic word_done;
    logic drop;
    logic ovr_q;

    assign rx_evt = mst_rx_evt | slv_rx_evt;
    assign rx_pkt = (slv_en ? l_rword_q : rsh_q) & len_mask;
    assign rx_store = rx_evt & (~cfg.cmp_en | matched_q);
    assign amt = 6'(acnt_q * psize);
    assign word_done = acnt_q + 3'h1 == ppw;
    assign drop = rx_store & word_done & pv_q & ~rxf_wready;

    always_ff @(posedge ref_clk) begin
        if (srst || !cfg.cmp_en) begin
            matched_q <= 1'b0;
        end else if (rx_evt && rx_pkt == (cmp_pattern & len_mask)) begin
            matched_q <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || !cfg.enable) begin
            acc_q <= '0;
            acnt_q <= 3'h0;
            pv_q <= 1'b0;
            pd_q <= '0;
        end else begin
            if (pv_q && rxf_wready) begin
                pv_q <= 1'b0;
            end
            if (rx_store && word_done) begin
                if (!drop) begin
                    pd_q <= acc_q | (rx_pkt << amt);
                    pv_q <= 1'b1;
                end
                acc_q <= '0;
                acnt_q <= 3'h0;
            end else if (rx_store) begin
                acc_q <= acc_q | (rx_pkt << amt);
                acnt_q <= acnt_q + 3'h1;
            end
        end
    end

    // A drop in the clearing cycle keeps the flag set
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ovr_q <= 1'b0;
        end else if (drop) begin
            ovr_q <= 1'b1;
        end else if (ovr_clr) begin
            ovr_q <= 1'b0;
        end
    end

    assign rxf_wvalid = pv_q;
    assign rxf_wdata = pd_q;
    assign rx_overrun = ovr_q;
    assign cmp_matched = matched_q;
    assign busy = (st_q != spi_pkg::M_IDLE) | tx_avail | pv_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    sck_half_min_a: assert property (mst_en && !$stable(sck_q) |=> $stable(sck_q)[*2])
        else $error("serial clock half period below limit");
    pins_master_a: assert property (mst_en |-> !sck_oe_n && !mosi_oe_n && miso_oe_n)
        else $error("master pin drive wrong");
    idle_pol_a: assert property (st_q == spi_pkg::M_SETUP |-> sck_q == cfg.cpol)
        else $error("idle clock level not polarity");
    sample_parity_a: assert property (sample_now |-> sck_q == (cfg.cpol ^ cfg.cpha))
        else $error("sample on launch edge");
    edge_count_a: assert property (
        st_q == spi_pkg::M_HOLD && $past(st_q) == spi_pkg::M_SHIFT
        |-> eidx_q == {1'b0, len, 1'b0} + 7'h02)
        else $error("wrong edge count per packet");
    pack_ratio_a: assert property (
        cfg.packed_en && len == `SPI_PACK8_LEN |-> ppw == `SPI_PACK8_PPW)
        else $error("packed 8 bit ratio wrong");
    auto_cs_a: assert property (
        mst_en && !cfg.sw_cs && $stable(cfg) && st_q == spi_pkg::M_GAP |=> cs_n_drive == '1)
        else $error("select held between packets");
    cmp_gate_a: assert property (rxf_wvalid && !$past(rxf_wvalid) |-> !cfg.cmp_en || matched_q)
        else $error("stored before pattern match");
    cs_other_a: assert property (mst_en && $stable(cfg) |=> cs_n_drive[~cfg.cs_sel])
        else $error("unselected line asserted");
    slave_quiet_a: assert property (cs_n_line[0] |-> miso_oe_n)
        else $error("slave drives while deselected");

endmodule : spi_ctrl

// ==== spi_peer_model.sv ====
`timescale 1ns/1ps

module spi_peer_model (
    // Link lines
    input wire logic sck,
    input wire logic mosi,
    input wire logic cs_n,
    output logic miso,
    // Mode and data
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [4:0] len,
    input wire logic [31:0] reply,
    output logic [31:0] got
);
    logic [31:0] sr = 32'h0;
    logic started = 1'b0;

    initial got = 32'h0;
    initial miso = 1'b0;

    always @(negedge cs_n) begin
        sr = reply;
        started = 1'b0;
        got = 32'h0;
    end

    // Sample edge is the first edge from idle when phase is zero
    always @(sck) begin
        if (cs_n === 1'b0) begin
            if (sck === (cpol ~^ cpha)) begin
                got = {got[30:0], mosi};
            end else begin
                if (!cpha || started) sr = sr << 1;
                started = 1'b1;
            end
        end
    end

    // Released line shows the inverse, so a stale bit never reads as valid
    always @(cs_n or sr or len) begin
        if (cs_n === 1'b0) miso = sr[len];
        else miso = ~miso;
    end
endmodule : spi_peer_model

// ==== spi_master_slave_controller_tb.sv ====
`timescale 1ns/1ps

module spi_master_slave_controller_tb;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    spi_pkg::cfg_t cfg = '0;
    logic [31:0] cmp_pattern = 32'h0;
    logic ovr_clr = 1'b0;
    logic tx_valid = 1'b0;
    logic [31:0] tx_data = 32'h0;
    logic rx_ready = 1'b0;
    logic busy, cmp_matched, rx_overrun, tx_ready, rx_valid;
    logic [31:0] rx_data, peer_got;
    logic [31:0] peer_reply = 32'h0;
    logic sck_drive, sck_oe_n, mosi_drive, mosi_oe_n, miso_drive, miso_oe_n, peer_miso;
    logic [1:0] cs_n_drive, cs_oe_n;
    logic b_sck = 1'b0;
    logic b_mosi = 1'b0;
    logic b_cs_n = 1'b1;
    logic [31:0] seed = 32'h44;
    int err_count = 0;
    int cmp_count = 0;
    wire logic sck_line = sck_oe_n ? b_sck : sck_drive;
    wire logic mosi_line = mosi_oe_n ? b_mosi : mosi_drive;
    wire logic miso_line = miso_oe_n ? peer_miso : miso_drive;
    wire logic [1:0] cs_n_line = {cs_oe_n[1] ? 1'b1 : cs_n_drive[1],
                                  cs_oe_n[0] ? b_cs_n : cs_n_drive[0]};

    initial forever #2.5 ref_clk = ~ref_clk;

    spi_ctrl i_spi_ctrl (.ref_clk(ref_clk), .srst(srst), .cfg(cfg), .cmp_pattern(cmp_pattern),
        .ovr_clr(ovr_clr), .busy(busy), .cmp_matched(cmp_matched), .rx_overrun(rx_overrun),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_ready(rx_ready), .sck_line(sck_line), .sck_drive(sck_drive),
        .sck_oe_n(sck_oe_n), .mosi_line(mosi_line), .mosi_drive(mosi_drive),
        .mosi_oe_n(mosi_oe_n), .miso_line(miso_line), .miso_drive(miso_drive),
        .miso_oe_n(miso_oe_n), .cs_n_line(cs_n_line), .cs_n_drive(cs_n_drive),
        .cs_oe_n(cs_oe_n));

    spi_peer_model i_spi_peer_model (.sck(sck_line), .mosi(mosi_line),
        .cs_n(cs_n_line[0] | ~cfg.master), .miso(peer_miso), .cpol(cfg.cpol),
        .cpha(cfg.cpha), .len(cfg.bit_len), .reply(peer_reply), .got(peer_got));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [31:0] mask_of(input logic [4:0] l);
        return 32'hffffffff >> (5'h1f - l);
    endfunction : mask_of

    function automatic spi_pkg::cfg_t mk(input logic ms, input logic pol, input logic pha,
                                         input logic [4:0] len);
        spi_pkg::cfg_t r;
        logic [31:0] v;
        v = rnd();
        r = '0;
        r.enable = 1'b1;
        r.master = ms;
        r.cpol = pol;
        r.cpha = pha;
        r.bit_len = len;
        r.half_div = {6'h00, v[1:0]} + 8'h02;
        return r;
    endfunction : mk

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    // Config only changes while disabled, as the engine expects
    task automatic set_cfg(input spi_pkg::cfg_t c);
        @(posedge ref_clk);
        cfg.enable <= 1'b0;
        @(posedge ref_clk);
        cfg <= c;
        repeat (4) @(posedge ref_clk);
    endtask : set_cfg

    task automatic push(input logic [31:0] w);
        @(posedge ref_clk);
        tx_valid <= 1'b1;
        tx_data <= w;
        do @(posedge ref_clk); while (tx_ready !== 1'b1);
        tx_valid <= 1'b0;
    endtask : push

    task automatic pull(output logic [31:0] w);
        int n;
        n = 0;
        w = 32'h0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rx_valid !== 1'b1 && n < 3000);
        if (rx_valid !== 1'b1) begin
            check(32'h0, 32'h1, "rx word wait");
        end else begin
            w = rx_data;
            rx_ready <= 1'b1;
            @(posedge ref_clk);
            rx_ready <= 1'b0;
        end
    endtask : pull

    task automatic frame(input logic [31:0] tx, input logic [31:0] rep,
                         input logic [31:0] er, input logic [31:0] ep);
        logic [31:0] w;
        peer_reply <= rep;
        push(tx);
        pull(w);
        check(w, er, "master rx");
        check(peer_got, ep, "peer rx");
    endtask : frame

    // Link clock is set to its idle level before select falls, then toggles inside the select window
    task automatic slave_frame(input int n, input logic [31:0] s, output logic [31:0] got);
        got = 32'h0;
        b_sck = cfg.cpol;
        #37 b_cs_n = 1'b0;
        #160;
        for (int i = n - 1; i >= 0; i--) begin
            if (cfg.cpha) b_sck = ~b_sck;
            b_mosi = s[i];
            #80;
            got = {got[30:0], miso_line};
            b_sck = ~b_sck;
            #80;
            if (!cfg.cpha) b_sck = ~b_sck;
        end
        #160 b_cs_n = 1'b1;
        b_mosi = ~b_mosi;
    endtask : slave_frame

    initial begin
        #400000;
        err_count++;
        give_verdict();
    end

    initial begin
        logic [31:0] w, t, s;
        spi_pkg::cfg_t c;
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        #1;
        check({29'h0, busy, tx_ready, rx_valid}, 32'h2, "reset flow");
        check({30'h0, cs_n_drive}, 32'h3, "reset select");
        $display("test reset done");
        for (int m = 0; m < 12; m++) begin
            w = rnd();
            c = mk(1'b1, m[1], m[0], (m < 4) ? 5'h00 : (m < 8) ? 5'h1f : w[4:0]);
            set_cfg(c);
            t = rnd();
            s = rnd();
            frame(t, s, s & mask_of(c.bit_len), t & mask_of(c.bit_len));
        end
        $display("test modes done");
        c = mk(1'b1, 1'b0, 1'b0, 5'h07);
        c.packed_en = 1'b1;
        set_cfg(c);
        t = rnd();
        s = rnd();
        frame(t, s, {4{s[7:0]}}, {24'h0, t[31:24]});
        c.bit_len = 5'h0f;
        set_cfg(c);
        frame(t, s, {2{s[15:0]}}, {16'h0, t[31:16]});
        $display("test packed done");
        c = mk(1'b1, 1'b1, 1'b0, 5'h07);
        c.cmp_en = 1'b1;
        cmp_pattern <= 32'h000000a5;
        set_cfg(c);
        peer_reply <= 32'h000000a5;
        push(32'h0);
        for (int n = 0; n < 2000 && cmp_matched !== 1'b1; n++) @(posedge ref_clk);
        repeat (8) @(posedge ref_clk);
        check({31'h0, cmp_matched}, 32'h1, "match flag");
        check({31'h0, rx_valid}, 32'h0, "pattern dropped");
        frame(32'h0, 32'h3c, 32'h3c, 32'h0);
        $display("test compare done");
        c = mk(1'b1, 1'b0, 1'b0, 5'h07);
        c.sw_cs = 1'b1;
        c.sw_cs_level = 1'b1;
        c.cs_sel = 1'b1;
        set_cfg(c);
        check({30'h0, cs_n_drive}, 32'h1, "soft select");
        cfg.sw_cs_level <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check({30'h0, cs_n_drive}, 32'h3, "soft release");
        $display("test select done");
        c = mk(1'b1, 1'b0, 1'b0, 5'h07);
        c.enable = 1'b0;
        set_cfg(c);
        peer_reply <= 32'h5a;
        for (int i = 0; i < 4; i++) push(rnd());
        @(posedge ref_clk);
        tx_valid <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({31'h0, tx_ready}, 32'h0, "tx full");
        tx_valid <= 1'b0;
        cfg.enable <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check({31'h0, busy}, 32'h1, "busy while sending");
        repeat (596) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            pull(w);
            check(w, 32'h5a, "drained");
        end
        $display("test fill done");
        for (int m = 0; m < 2; m++) begin
            c = mk(1'b0, m[0], m[0], 5'h07);
            b_sck = m[0];
            set_cfg(c);
            t = rnd();
            s = rnd();
            push(t);
            repeat (10) @(posedge ref_clk);
            slave_frame(8, s, w);
            check(w, {24'h0, t[7:0]}, "slave out");
            pull(w);
            check(w, {24'h0, s[7:0]}, "slave in");
        end
        c = mk(1'b0, 1'b0, 1'b0, 5'h00);
        set_cfg(c);
        slave_frame(8, 32'h5a, w);
        repeat (20) @(posedge ref_clk);
        check({31'h0, rx_overrun}, 32'h1, "overrun");
        ovr_clr <= 1'b1;
        @(posedge ref_clk);
        ovr_clr <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check({31'h0, rx_overrun}, 32'h0, "overrun clear");
        $display("test slave done");
        give_verdict();
    end
endmodule : spi_master_slave_controller_tb
